// ---- rtl/lcd_tv_port_map.svh ----
// Offsets, field positions, reset values and clock limits of the video output port
`ifndef LCD_TV_PORT_MAP_SVH
`define LCD_TV_PORT_MAP_SVH

// Register offsets
`define REG_CTRL        4'h0
`define REG_TIMING_H    4'h1
`define REG_TIMING_V    4'h2
`define REG_BORDER      4'h3
`define REG_PIXEL       4'h4
`define REG_STATUS      4'h5
`define REG_INT_CLEAR   4'h6
`define REG_INT_ENABLE  4'h7
`define REG_LINK        4'h8
`define REG_POSITION    4'h9

// Control fields
`define CTRL_ENABLE     0
`define CTRL_TV_MODE    1
`define CTRL_BORDER_MD  2
`define CTRL_HS_POL     3
`define CTRL_VS_POL     4
`define CTRL_SINGLE_END 5
`define CTRL_DIV_LSB    8
`define CTRL_DIV_MSB    11

// Interrupt status fields
`define ST_PANEL_INT    0
`define ST_FRAME        1
`define ST_LINE         2

// Reset values
`define CTRL_RESET      32'h0000_0000
`define TIMING_H_RESET  32'h0020_0010
`define TIMING_V_RESET  32'h0010_0008
`define BORDER_RESET    32'h0002_0002
`define PIXEL_RESET     32'h0000_0000

// Pixel clock limits in kHz and the local clock rate
`define CLK_KHZ         20000
`define OUT_MAX_KHZ     85000
`define SINGLE_MAX_KHZ  65000
`define ENC_MIN_KHZ     20000
`define ENC_MAX_KHZ     40000

`endif

// ---- rtl/lcd_tv_port_pkg.sv ----
// Types shared by the video output port
package lcd_tv_port_pkg;

  typedef struct packed {
    logic [11:0] data;
    logic        hsync;
    logic        vsync;
    logic        blank_n;
  } pixel_out_t;

  typedef struct packed {
    logic [15:0] total;
    logic [15:0] active;
  } timing_t;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } od_pin_t;

endpackage

// ---- rtl/pin_sync.sv ----
// Two flip-flop synchroniser for pins from outside the clock domain
module pin_sync (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic pin_i,
  input  wire logic reset_val_i,
  output logic      level_o
);

  logic meta;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta    <= reset_val_i;
      level_o <= reset_val_i;
    end else begin
      meta    <= pin_i;
      level_o <= meta;
    end
  end

endmodule

// ---- rtl/lcd_tv_port.sv ----
// Digital video output port toward a TV encoder or flat panel
//
// Summary of operation
// - TV mode: encoder clock on the shared pin paces pixel output.
// - Panel mode: shared pin is an active-low interrupt input.
// - Port clock leaves as a differential pair, up to 85 MHz.
// - Single-ended mode below 65 MHz: bit 0 clocks, bit 1 unused.
// - Pixel data leaves on a 12-bit bus.
// - Each sync has a software selected active polarity.
// - Two-wire control link, open drain, pull low or release.
//
// Chosen here: the address-and-strobe port and the register offsets.
`include "lcd_tv_port_map.svh"

module lcd_tv_port
  import lcd_tv_port_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        encoder_pixel_clock_in_i,
  output logic      [1:0]  port_clock_out_o,
  output logic             blank_border_n_o,
  output logic      [11:0] port_pixel_data_o,
  output logic             port_vertical_sync_o,
  output logic             port_horizontal_sync_o,
  input  wire logic        port_ctl_scl_i,
  output logic             port_ctl_scl_o,
  output logic             port_ctl_scl_oe_o,
  input  wire logic        port_ctl_sda_i,
  output logic             port_ctl_sda_o,
  output logic             port_ctl_sda_oe_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  timing_t     tim_h;
  timing_t     tim_v;
  logic [31:0] border;
  logic [11:0] pixel;
  logic [2:0]  status;
  logic [2:0]  int_en;
  logic [1:0]  link_drive_low;
  logic [2:0]  events;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl   <= `CTRL_RESET;
      tim_h  <= `TIMING_H_RESET;
      tim_v  <= `TIMING_V_RESET;
      border <= `BORDER_RESET;
      pixel  <= 12'h000;
      int_en <= 3'h0;
      link_drive_low <= 2'b00;
    end else if (wr_i) begin
      if (hit(addr_i, `REG_CTRL))       ctrl   <= wdata_i;
      if (hit(addr_i, `REG_TIMING_H))   tim_h  <= wdata_i;
      if (hit(addr_i, `REG_TIMING_V))   tim_v  <= wdata_i;
      if (hit(addr_i, `REG_BORDER))     border <= wdata_i;
      if (hit(addr_i, `REG_PIXEL))      pixel  <= wdata_i[11:0];
      if (hit(addr_i, `REG_INT_ENABLE)) int_en <= wdata_i[2:0];
      if (hit(addr_i, `REG_LINK))       link_drive_low <= wdata_i[1:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~((wr_i && hit(addr_i, `REG_INT_CLEAR)) ? wdata_i[2:0] : 3'h0))
                | events;
    end
  end

  assign irq_o = |(status & int_en);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic enc_pin;
  logic scl_in;
  logic sda_in;

  pin_sync u_enc (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .pin_i      (encoder_pixel_clock_in_i),
    .reset_val_i(1'b1),
    .level_o    (enc_pin)
  );

  pin_sync u_scl (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .pin_i      (port_ctl_scl_i),
    .reset_val_i(1'b1),
    .level_o    (scl_in)
  );

  pin_sync u_sda (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .pin_i      (port_ctl_sda_i),
    .reset_val_i(1'b1),
    .level_o    (sda_in)
  );

  // ----------------------------------------------------------------
  // Pixel clock selection
  // ----------------------------------------------------------------
  logic       tv_mode;
  logic       enc_prev;
  logic [3:0] div_cnt;
  logic       gen_clk;
  logic       pix_tick;
  logic       enc_rise;

  assign tv_mode  = ctrl[`CTRL_TV_MODE];
  assign enc_rise = enc_pin & ~enc_prev;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) enc_prev <= 1'b1;
    else         enc_prev <= enc_pin;
  end

  // Local divider: half period is divisor+1 cycles
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !ctrl[`CTRL_ENABLE]) begin
      div_cnt <= 4'h0;
      gen_clk <= 1'b0;
    end else if (div_cnt == ctrl[`CTRL_DIV_MSB:`CTRL_DIV_LSB]) begin
      div_cnt <= 4'h0;
      gen_clk <= ~gen_clk;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  always_comb begin
    if (!ctrl[`CTRL_ENABLE])
      pix_tick = 1'b0;
    else if (tv_mode)
      pix_tick = enc_rise;
    else
      pix_tick = gen_clk && (div_cnt == ctrl[`CTRL_DIV_MSB:`CTRL_DIV_LSB]);
  end

  // Differential pair, or bit 0 only in single-ended mode
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_clock_out_o <= 2'b10;
    end else begin
      port_clock_out_o[0] <= tv_mode ? enc_pin : gen_clk;
      port_clock_out_o[1] <= ctrl[`CTRL_SINGLE_END] ? 1'b0
                           : ~(tv_mode ? enc_pin : gen_clk);
    end
  end

  // ----------------------------------------------------------------
  // Raster timing
  // ----------------------------------------------------------------
  logic [15:0] hcnt;
  logic [15:0] vcnt;
  logic        h_end;
  logic        v_end;

  assign h_end = hcnt == tim_h.total - 16'h1;
  assign v_end = vcnt == tim_v.total - 16'h1;

  always_ff @(posedge clk_i) begin
    if (!nrst_i || !ctrl[`CTRL_ENABLE]) begin
      hcnt <= 16'h0;
      vcnt <= 16'h0;
    end else if (pix_tick) begin
      hcnt <= h_end ? 16'h0 : hcnt + 16'h1;
      if (h_end) vcnt <= v_end ? 16'h0 : vcnt + 16'h1;
    end
  end

  logic in_active;
  logic in_border;
  logic hs_act;
  logic vs_act;

  assign in_active = (hcnt < tim_h.active) && (vcnt < tim_v.active);
  assign in_border = (hcnt < tim_h.active + {8'h0, border[7:0]})
                  && (vcnt < tim_v.active + {8'h0, border[23:16]});
  assign hs_act    = hcnt >= tim_h.total - 16'h2;
  assign vs_act    = vcnt >= tim_v.total - 16'h1;

  // ----------------------------------------------------------------
  // Output stage, all fields on one edge
  // ----------------------------------------------------------------
  pixel_out_t next_out;

  always_comb begin
    next_out.data    = in_active ? pixel : 12'h000;
    next_out.hsync   = hs_act ^ ~ctrl[`CTRL_HS_POL];
    next_out.vsync   = vs_act ^ ~ctrl[`CTRL_VS_POL];
    next_out.blank_n = ctrl[`CTRL_BORDER_MD] ? in_border : in_active;
  end

  pixel_out_t out_q;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      out_q <= {12'h000, 1'b1, 1'b1, 1'b0};
    end else if (pix_tick) begin
      out_q <= next_out;
    end
  end

  assign port_pixel_data_o      = out_q.data;
  assign port_horizontal_sync_o = out_q.hsync;
  assign port_vertical_sync_o   = out_q.vsync;
  assign blank_border_n_o       = out_q.blank_n;

  // ----------------------------------------------------------------
  // Events and two-wire link
  // ----------------------------------------------------------------
  always_comb begin
    events                = 3'h0;
    events[`ST_PANEL_INT] = !tv_mode && !enc_pin;
    events[`ST_FRAME]     = pix_tick && h_end && v_end;
    events[`ST_LINE]      = pix_tick && h_end;
  end

  assign port_ctl_scl_o    = 1'b0;
  assign port_ctl_sda_o    = 1'b0;
  assign port_ctl_scl_oe_o = link_drive_low[0];
  assign port_ctl_sda_oe_o = link_drive_low[1];

  always_ff @(posedge clk_i) begin
    if (!nrst_i) rdata_o <= 32'h0000_0000;
    else if (rd_i) begin
      unique case (addr_i)
        `REG_CTRL:       rdata_o <= ctrl;
        `REG_TIMING_H:   rdata_o <= tim_h;
        `REG_TIMING_V:   rdata_o <= tim_v;
        `REG_BORDER:     rdata_o <= border;
        `REG_PIXEL:      rdata_o <= {20'h0_0000, pixel};
        `REG_STATUS:     rdata_o <= {29'h0000_0000, status};
        `REG_INT_ENABLE: rdata_o <= {29'h0000_0000, int_en};
        `REG_LINK:       rdata_o <= {28'h000_0000, sda_in, scl_in, link_drive_low};
        `REG_POSITION:   rdata_o <= {vcnt, hcnt};
        default:         rdata_o <= 32'h0000_0000;
      endcase
    end else rdata_o <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence tick_s;
    pix_tick;
  endsequence

  AST_TV_PACE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(port_pixel_data_o) && $past(tv_mode) |-> $past(enc_rise))
    else $error("pixel data changed without encoder edge");
  AST_PANEL_IRQ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !tv_mode && !enc_pin |=> status[`ST_PANEL_INT])
    else $error("panel interrupt not latched");
  AST_DIFF_PAIR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !$past(ctrl[`CTRL_SINGLE_END]) && !$past(!nrst_i) |->
      port_clock_out_o[1] == ~port_clock_out_o[0])
    else $error("clock pair not complementary");
  AST_SINGLE_END: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(ctrl[`CTRL_SINGLE_END]) |-> !port_clock_out_o[1])
    else $error("clock bit 1 driven in single-ended mode");
  AST_BLANK_MODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 !ctrl[`CTRL_BORDER_MD] |=> blank_border_n_o == $past(in_active))
    else $error("blank output does not follow active area");
  AST_DATA_BLANK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 !in_active |=> port_pixel_data_o == 12'h000)
    else $error("pixel data outside active area");
  AST_HS_POL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 !hs_act |=> port_horizontal_sync_o == !$past(ctrl[`CTRL_HS_POL]))
    else $error("horizontal sync idle level wrong");
  AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !port_ctl_scl_o && !port_ctl_sda_o)
    else $error("two-wire link driven high");
  AST_SAME_EDGE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(port_horizontal_sync_o) || $changed(blank_border_n_o) |-> $past(pix_tick))
    else $error("outputs changed off the pixel edge");
  AST_MODE_SEL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !tv_mode && enc_rise && !gen_clk |-> !pix_tick)
    else $error("encoder clock used in panel mode");
  AST_TV_SEL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tv_mode && ctrl[`CTRL_ENABLE] |-> pix_tick == enc_rise)
    else $error("pixel pace not taken from encoder clock");
  AST_TV_CLOCK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tv_mode |=> port_clock_out_o[0] == $past(enc_pin))
    else $error("port clock does not follow encoder clock");
  AST_SINGLE_CLK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(ctrl[`CTRL_SINGLE_END]) && !$past(tv_mode) |->
      port_clock_out_o[0] == $past(gen_clk))
    else $error("clock bit 0 lost in single-ended mode");

  // ----------------------------------------------------------------
  // Raster output checks
  // ----------------------------------------------------------------
  AST_VS_POL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 !vs_act |=> port_vertical_sync_o == !$past(ctrl[`CTRL_VS_POL]))
    else $error("vertical sync idle level wrong");
  AST_HS_ACTIVE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 hs_act |=> port_horizontal_sync_o == $past(ctrl[`CTRL_HS_POL]))
    else $error("horizontal sync active level wrong");
  AST_VS_ACTIVE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 vs_act |=> port_vertical_sync_o == $past(ctrl[`CTRL_VS_POL]))
    else $error("vertical sync active level wrong");
  AST_BORDER_MODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 ctrl[`CTRL_BORDER_MD] |=> blank_border_n_o == $past(in_border))
    else $error("blank output does not follow border area");
  AST_DATA_ACTIVE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick_s ##0 in_active |=> port_pixel_data_o == $past(pixel))
    else $error("pixel data wrong inside active area");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !$past(pix_tick) |-> $stable(port_pixel_data_o) && $stable(port_vertical_sync_o))
    else $error("outputs moved between pixel edges");

  // ----------------------------------------------------------------
  // Interrupt checks
  // ----------------------------------------------------------------
  // Panel status stays set until software clears it
  sequence panel_kept_s;
    status[`ST_PANEL_INT] && !(wr_i && hit(addr_i, `REG_INT_CLEAR) && wdata_i[`ST_PANEL_INT]);
  endsequence

  AST_PANEL_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    panel_kept_s |=> status[`ST_PANEL_INT])
    else $error("panel interrupt status lost without clear");
  AST_IRQ_OUT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    status[`ST_PANEL_INT] && int_en[`ST_PANEL_INT] |-> irq_o)
    else $error("enabled panel interrupt not signalled");

endmodule

// ---- tb/encoder_model.sv ----
// Encoder or panel model on the far side of the video port
module encoder_model (
  input  wire logic run_i,
  input  wire logic tv_mode_i,
  input  wire logic int_req_i,
  input  wire logic scl_pull_i,
  input  wire logic sda_pull_i,
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  output logic      pin_o,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  parameter int HALF_NS = 200;
  logic pclk = 1'b0;
  // Scaled pixel clock, halts when not running
  always begin
    #HALF_NS;
    if (run_i) pclk = ~pclk;
  end
  // Shared pin: pixel clock or pulled-up interrupt
  assign pin_o = tv_mode_i ? pclk : ~int_req_i;
  // Open drain with pull-up
  assign scl_o = ~(scl_oe_i | scl_pull_i);
  assign sda_o = ~(sda_oe_i | sda_pull_i);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the video output port
`include "lcd_tv_port_map.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, nrst_i, wr_i, rd_i, pin, blank_n, hs, vs, irq;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, rv, pix;
  logic [1:0]  clk_out;
  logic [11:0] pdata;
  logic        scl_in, scl_o, scl_oe, sda_in, sda_o, sda_oe;
  logic        run, tv, int_req, scl_pull, sda_pull;
  int          miscompares, n_compared, cycles, seed, k, ha, va, bc[2], d, ch;
  lcd_tv_port dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .encoder_pixel_clock_in_i(pin),
    .port_clock_out_o(clk_out), .blank_border_n_o(blank_n), .port_pixel_data_o(pdata),
    .port_vertical_sync_o(vs), .port_horizontal_sync_o(hs), .port_ctl_scl_i(scl_in),
    .port_ctl_scl_o(scl_o), .port_ctl_scl_oe_o(scl_oe), .port_ctl_sda_i(sda_in),
    .port_ctl_sda_o(sda_o), .port_ctl_sda_oe_o(sda_oe), .irq_o(irq));
  encoder_model encoder (.run_i(run), .tv_mode_i(tv), .int_req_i(int_req),
    .scl_pull_i(scl_pull), .sda_pull_i(sda_pull), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .pin_o(pin), .scl_o(scl_in), .sda_o(sda_in));
  // ----------------------------------------
  // Clock, timeout and bus tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  function automatic logic [31:0] ctrl(logic t, logic b, logic h, logic v, logic s,
                                       logic [3:0] dv);
    return {20'h0_0000, dv, 2'b00, s, v, h, b, t, 1'b1};
  endfunction
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] dt);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= dt;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    `CHK(rdata_o & m, e)
  endtask
  task automatic half_period(output int n);
    logic p;
    @(negedge clk_i);
    p = clk_out[0];
    for (n = 0; n < 40 && clk_out[0] === p; n++) @(negedge clk_i);
    p = clk_out[0];
    for (n = 0; n < 40 && clk_out[0] === p; n++) @(negedge clk_i);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {nrst_i, wr_i, rd_i, addr_i, wdata_i, tv, int_req, scl_pull, sda_pull} = '0;
    run = 1'b1;
    seed = 32'h0000_9509;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    `CHK(clk_out, 2'b10)
    `CHK({pdata, blank_n, irq, scl_oe, sda_oe}, 16'h0000)
    `CHK({hs, vs}, 2'b11)
    rd_chk(`REG_TIMING_H, '1, `TIMING_H_RESET);
    rd_chk(`REG_TIMING_V, '1, `TIMING_V_RESET);
    rd_chk(`REG_BORDER, '1, `BORDER_RESET);
    reg_wr(4'hC, 32'hFFFF_FFFF);
    rd_chk(4'hC, '1, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = i % 4;
      reg_wr(`REG_CTRL, ctrl(0, 0, 1, 1, i[2], d[3:0]));
      half_period(k);
      `CHK(k, d + 1)
      `CHK(clk_out[1], i[2] ? 1'b0 : ~clk_out[0])
    end
    $display("test clock out done");
    for (int p = 0; p < 4; p++) begin
      pix = $random(seed);
      reg_wr(`REG_PIXEL, pix);
      reg_wr(`REG_CTRL, ctrl(0, 0, p[0], p[1], 0, 4'($random(seed) & 3)));
      repeat (40) @(negedge clk_i);
      ha = 0;
      va = 0;
      k = 0;
      repeat (4200) begin
        @(negedge clk_i);
        ha += (hs === p[0]);
        va += (vs === p[1]);
        k += (blank_n === 1'b1 && pdata !== pix[11:0]);
      end
      `CHK(ha > 0 && ha * 8 < 4200, 1'b1)
      `CHK(va > 0 && va * 4 < 4200, 1'b1)
      `CHK(k, 0)
    end
    $display("test sync data done");
    for (int b = 0; b < 2; b++) begin
      reg_wr(`REG_CTRL, ctrl(0, b, 1, 1, 0, 0));
      bc[b] = 0;
      repeat (4200) @(negedge clk_i) bc[b] += (blank_n === 1'b1);
    end
    `CHK(bc[0] > 0 && bc[1] > bc[0], 1'b1)
    $display("test blank done");
    tv = 1'b1;
    reg_wr(`REG_CTRL, ctrl(1, 0, 1, 1, 0, 0));
    ch = 0;
    rv[0] = hs;
    repeat (4200) begin
      @(negedge clk_i);
      ch += (hs !== rv[0]);
      rv[0] = hs;
    end
    `CHK(ch > 0, 1'b1)
    run = 1'b0;
    repeat (20) @(negedge clk_i);
    rv = {pdata, hs, vs, blank_n};
    ch = 0;
    repeat (200) @(negedge clk_i) ch += ({pdata, hs, vs, blank_n} !== rv[14:0]);
    `CHK(ch, 0)
    `CHK({pdata, hs, vs, blank_n}, rv[14:0])
    run = 1'b1;
    $display("test tv mode done");
    tv = 1'b0;
    reg_wr(`REG_CTRL, ctrl(0, 0, 1, 1, 0, 0));
    reg_wr(`REG_INT_ENABLE, 32'h0000_0001);
    reg_wr(`REG_INT_CLEAR, 32'h0000_0007);
    int_req <= 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK(irq, 1'b1)
    rd_chk(`REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    int_req <= 1'b0;
    repeat (6) @(posedge clk_i);
    reg_wr(`REG_INT_CLEAR, 32'h0000_0001);
    rd_chk(`REG_STATUS, 32'h0000_0001, 32'h0000_0000);
    `CHK(irq, 1'b0)
    reg_wr(`REG_INT_ENABLE, 32'h0000_0000);
    int_req <= 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK(irq, 1'b0)
    int_req <= 1'b0;
    reg_wr(`REG_INT_ENABLE, 32'h0000_0002);
    repeat (4200) @(negedge clk_i);
    `CHK(irq, 1'b1)
    reg_wr(`REG_INT_ENABLE, 32'h0000_0000);
    $display("test interrupt done");
    for (int i = 0; i < 16; i++) begin
      scl_pull <= i[2];
      sda_pull <= i[3];
      reg_wr(`REG_LINK, 32'(i[1:0]));
      repeat (4) @(posedge clk_i);
      `CHK({scl_oe, sda_oe, scl_o, sda_o}, {i[0], i[1], 2'b00})
      rd_chk(`REG_LINK, 32'h0000_000C, {28'h0, ~(i[1] | i[3]), ~(i[0] | i[2]), 2'b00});
    end
    $display("test link done");
    stop_test();
  end
endmodule
